// file: core/sio_regs.svh
// register offsets, field positions, reset values and timing counts of the serial block
// assumes a 16-bit APB byte address with one 32-bit word per register
`ifndef SIO_REGS_SVH
`define SIO_REGS_SVH

`define SIO_CTL_ADDR 16'hFFB0
`define SIO_SHIFT_ADDR 16'hFFB4
`define SIO_STAT_ADDR 16'hFFB8

`define SIO_CTL_RESET 8'h00
`define SIO_CTL_WMASK 8'h87
`define SIO_EN_BIT 7
`define SIO_MODE_BIT 2
`define SIO_SEL_HI 1
`define SIO_SEL_LO 0

`define SIO_STAT_DONE 0
`define SIO_STAT_BUSY 1

`define SIO_HALF_DIV64 8'h20
`define SIO_HALF_DIV128 8'h40
`define SIO_HALF_DIV256 8'h80
`define SIO_LAST_BIT 3'h7

`endif

// file: core/sio_pkg.sv
// types shared by the serial block
// assumes nothing of its surroundings
package sio_pkg;

    typedef enum logic [1:0]
    {
        SEL_EXT = 2'b00,
        SEL_DIV64 = 2'b01,
        SEL_DIV128 = 2'b10,
        SEL_DIV256 = 2'b11
    } clk_sel_e;

    typedef enum logic
    {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } xfer_state_e;

    typedef struct packed
    {
        logic sck_out;
        logic sck_oe;
        logic so_out;
        logic so_oe;
    } sio_pins_s;

endpackage

// file: core/three_wire_serial_io.sv
// three-wire clock-synchronous serial interface with an APB register slave
// assumes a 40 MHz clk; the pads and port latches sit outside and follow the enables
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sio_regs.svh"

module three_wire_serial_io
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire logic sck_in,
    input wire logic si_in,
    output sio_pkg::sio_pins_s pins,
    // status
    output logic transfer_done_flag,
    output logic busy
);
    import sio_pkg::*;

    // ************************************************************
    // register bus decode
    // ************************************************************
    logic setup_ph;
    logic wr_acc;
    logic rd_acc;
    logic sel_ctl;
    logic sel_shift;
    logic sel_stat;
    logic mapped;

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign sel_ctl = paddr == `SIO_CTL_ADDR;
    assign sel_shift = paddr == `SIO_SHIFT_ADDR;
    assign sel_stat = paddr == `SIO_STAT_ADDR;
    assign mapped = sel_ctl || sel_shift || sel_stat;
    // zero wait states keep the slave simple; read data is caught at setup
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic sck_s1_r;
    logic sck_s2_r;
    logic sck_s3_r;
    logic si_s1_r;
    logic si_s2_r;
    logic si_s3_r;
    logic sck_lvl_r;
    logic sck_lvl_nxt;
    logic si_lvl_r;
    logic si_lvl_nxt;

    always_comb
    begin
        sck_lvl_nxt = sck_lvl_r;
        si_lvl_nxt = si_lvl_r;
        if (sck_s2_r == sck_s3_r)
        begin
            sck_lvl_nxt = sck_s3_r;
        end
        if (si_s2_r == si_s3_r)
        begin
            si_lvl_nxt = si_s3_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sck_s1_r <= 1'b1;
            sck_s2_r <= 1'b1;
            sck_s3_r <= 1'b1;
            si_s1_r <= 1'b0;
            si_s2_r <= 1'b0;
            si_s3_r <= 1'b0;
            sck_lvl_r <= 1'b1;
            si_lvl_r <= 1'b0;
        end
        else
        begin
            sck_s1_r <= sck_in;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            si_s1_r <= si_in;
            si_s2_r <= si_s1_r;
            si_s3_r <= si_s2_r;
            sck_lvl_r <= sck_lvl_nxt;
            si_lvl_r <= si_lvl_nxt;
        end
    end

    // ************************************************************
    // control state
    // ************************************************************
    logic [7:0] ctl_r;
    logic [7:0] ctl_nxt;
    xfer_state_e state_r;
    xfer_state_e state_nxt;
    logic [2:0] bitcnt_r;
    logic [2:0] bitcnt_nxt;
    logic [7:0] div_r;
    logic [7:0] div_nxt;
    logic sck_int_r;
    logic sck_int_nxt;
    logic so_r;
    logic so_nxt;
    logic done_r;
    logic done_nxt;
    logic [7:0] shreg_r;
    logic [7:0] shreg_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;

    logic en;
    logic rx_only;
    clk_sel_e csel;
    logic master;
    logic [7:0] half;
    logic trig;
    logic start_ok;
    logic tick;
    logic fall_ev;
    logic rise_ev;

    assign en = ctl_r[`SIO_EN_BIT];
    assign rx_only = ctl_r[`SIO_MODE_BIT];
    assign csel = clk_sel_e'({ctl_r[`SIO_SEL_HI], ctl_r[`SIO_SEL_LO]});
    assign master = csel != SEL_EXT;

    always_comb
    begin
        case (csel)
            SEL_DIV64: half = `SIO_HALF_DIV64;
            SEL_DIV128: half = `SIO_HALF_DIV128;
            SEL_DIV256: half = `SIO_HALF_DIV256;
            default: half = `SIO_HALF_DIV64;
        endcase
    end

    assign trig = sel_shift && ((wr_acc && !rx_only) || (rd_acc && rx_only));
    assign start_ok = en && (state_r == ST_IDLE) && (master ? sck_int_r : sck_lvl_r);

    assign tick = master && (state_r == ST_RUN) && (div_r == 8'h00);
    assign fall_ev = master ? (tick && sck_int_r) : (sck_lvl_r && !sck_lvl_nxt);
    assign rise_ev = master ? (tick && !sck_int_r) : (!sck_lvl_r && sck_lvl_nxt);

    always_comb
    begin
        ctl_nxt = ctl_r;
        state_nxt = state_r;
        bitcnt_nxt = bitcnt_r;
        div_nxt = div_r;
        sck_int_nxt = sck_int_r;
        so_nxt = so_r;
        done_nxt = done_r;
        shreg_nxt = shreg_r;
        prdata_nxt = prdata_r;

        if (setup_ph)
        begin
            prdata_nxt = 32'h0000_0000;
            if (sel_ctl)
            begin
                prdata_nxt[7:0] = ctl_r;
            end
            if (sel_shift)
            begin
                prdata_nxt[7:0] = shreg_r;
            end
            if (sel_stat)
            begin
                prdata_nxt[`SIO_STAT_DONE] = done_r;
                prdata_nxt[`SIO_STAT_BUSY] = state_r == ST_RUN;
            end
        end

        if (wr_acc && sel_ctl)
        begin
            ctl_nxt = pwdata[7:0] & `SIO_CTL_WMASK;
        end
        // write one to clear; a completion in the same cycle wins below
        if (wr_acc && sel_stat && pwdata[`SIO_STAT_DONE])
        begin
            done_nxt = 1'b0;
        end
        if (wr_acc && sel_shift && state_r == ST_IDLE)
        begin
            shreg_nxt = pwdata[7:0];
        end

        case (state_r)
            ST_IDLE:
            begin
                sck_int_nxt = 1'b1;
                bitcnt_nxt = 3'h0;
                if (trig && start_ok)
                begin
                    state_nxt = ST_RUN;
                    div_nxt = half - 8'h01;
                end
            end
            ST_RUN:
            begin
                if (tick)
                begin
                    div_nxt = half - 8'h01;
                    sck_int_nxt = !sck_int_r;
                end
                else if (master)
                begin
                    div_nxt = div_r - 8'h01;
                end
                if (fall_ev)
                begin
                    so_nxt = shreg_r[7];
                end
                if (rise_ev)
                begin
                    shreg_nxt = {shreg_r[6:0], si_lvl_r};
                    bitcnt_nxt = bitcnt_r + 3'h1;
                    if (bitcnt_r == `SIO_LAST_BIT)
                    begin
                        state_nxt = ST_IDLE;
                        done_nxt = 1'b1;
                    end
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase

        if (rx_only)
        begin
            so_nxt = 1'b0;
        end
        if (!en)
        begin
            state_nxt = ST_IDLE;
            bitcnt_nxt = 3'h0;
            sck_int_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_r <= `SIO_CTL_RESET;
            state_r <= ST_IDLE;
            bitcnt_r <= 3'h0;
            div_r <= 8'h00;
            sck_int_r <= 1'b1;
            so_r <= 1'b0;
            done_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            state_r <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            div_r <= div_nxt;
            sck_int_r <= sck_int_nxt;
            so_r <= so_nxt;
            done_r <= done_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        shreg_r <= shreg_nxt;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata = prdata_r;
    assign transfer_done_flag = done_r;
    assign busy = state_r == ST_RUN;
    assign pins.sck_out = sck_int_r;
    assign pins.sck_oe = en && master;
    assign pins.so_out = so_r;
    assign pins.so_oe = en && !rx_only;

endmodule
`default_nettype wire

// file: dv/sio_peer.sv
// serial peripheral model on the far side of the pins
// assumes the serial clock idles high between frames
`timescale 1ns/1ps
`default_nettype none
module sio_peer
(
    // serial pins
    input wire logic sck,
    input wire logic so,
    output logic si,
    // byte taken in
    output logic [7:0] rx
);
    logic [7:0] sh = 8'h00;
    int n = 8;
    initial
    begin
        si = 1'b0;
        rx = 8'h00;
    end
    task automatic load(input logic [7:0] d);
        sh = d;
        n = 0;
    endtask
    always @(negedge sck)
    begin
        if (n < 8)
        begin
            si = sh[7];
            sh = {sh[6:0], 1'b0};
        end
    end
    // line inverted 100 ns after bit eight
    always @(posedge sck)
    begin
        if (n < 8)
        begin
            rx = {rx[6:0], so};
            n++;
            if (n == 8)
                si <= #100 ~si;
        end
    end
endmodule
`default_nettype wire

// file: dv/three_wire_serial_io_sva.sv
// assertions on the serial block ports
// assumes the top module port names
`timescale 1ns/1ps
`default_nettype none
`include "sio_regs.svh"
module three_wire_serial_io_sva
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    // serial and status
    input wire sio_pkg::sio_pins_s pins,
    input wire logic transfer_done_flag,
    input wire logic busy
);
    import sio_pkg::*;
    logic [7:0] ctl_r;
    logic [3:0] nfall_r;
    logic sck_r;
    logic acc;
    assign acc = psel && penable;
    // mirror of the mode register, the body is out of sight
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_r <= 8'h00;
            nfall_r <= 4'h0;
            sck_r <= 1'b1;
        end
        else
        begin
            if (acc && pwrite && paddr == `SIO_CTL_ADDR)
                ctl_r <= pwdata[7:0] & `SIO_CTL_WMASK;
            sck_r <= pins.sck_out;
            nfall_r <= busy ? nfall_r + {3'h0, sck_r & ~pins.sck_out} : 4'h0;
        end
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_idle;
        !busy ##1 !busy;
    endsequence
    sequence s_start;
        acc && paddr == `SIO_SHIFT_ADDR && ctl_r[7] && pwrite != ctl_r[2] && !busy;
    endsequence
    a_sck_idle_high: assert property (s_idle |-> pins.sck_out)
        else $error("clock low while idle");
    a_pin_release: assert property (pins.so_oe == (ctl_r[7] && !ctl_r[2])
        && pins.sck_oe == (ctl_r[7] && ctl_r[1:0] != 2'b00))
        else $error("pin enable wrong");
    a_stop_disabled: assert property ((!ctl_r[7] ##1 !ctl_r[7]) |-> !busy)
        else $error("busy while disabled");
    a_start_busy: assert property (s_start |-> ##[1:3] busy)
        else $error("no start");
    a_first_fall: assert property ($rose(busy) && pins.sck_oe |-> pins.sck_out [*8])
        else $error("early clock fall");
    a_bit_held: assert property ($rose(pins.sck_out) |-> $stable(pins.so_out))
        else $error("output moved on rise");
    a_done_stop: assert property ($rose(transfer_done_flag) |-> $fell(busy)
        && (!pins.sck_oe || nfall_r == 4'h8))
        else $error("bad end of transfer");
    a_rx_out_low: assert property ((ctl_r[2] ##1 ctl_r[2]) |-> !pins.so_out)
        else $error("output not low");
    a_half_div64: assert property ($fell(pins.sck_out) && ctl_r[1:0] == 2'b01
        |-> ##32 $rose(pins.sck_out))
        else $error("div 64 period");
    a_half_div256: assert property ($fell(pins.sck_out) && ctl_r[1:0] == 2'b11
        |-> ##128 $rose(pins.sck_out))
        else $error("div 256 period");
endmodule
bind three_wire_serial_io three_wire_serial_io_sva chk (.clk, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pins, .transfer_done_flag, .busy);
`default_nettype wire

// file: dv/three_wire_serial_io_tb_top.sv
// bench of the serial block with a peer on the pins
// assumes core files and the peer compiled first
`timescale 1ns/1ps
`default_nettype none
`include "sio_regs.svh"
module three_wire_serial_io_tb_top;
    import sio_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, ext_sck = 1'b1;
    logic sck_w, so_w, si_w, transfer_done_flag, busy;
    logic [7:0] peer_rx;
    sio_pins_s pins;
    int failures = 0;
    int total_checks = 0;
    always #12.5 clk = ~clk;
    assign sck_w = pins.sck_oe ? pins.sck_out : ext_sck;
    assign so_w = pins.so_oe ? pins.so_out : 1'b1;
    three_wire_serial_io dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sck_in(sck_w), .si_in(si_w), .pins,
        .transfer_done_flag, .busy);
    sio_peer peer (.sck(sck_w), .so(so_w), .si(si_w), .rx(peer_rx));
    // ****************
    // tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        for (int n = 0; pready !== 1'b1; n++)
        begin
            if (n > 16)
            begin
                failures++;
                summarize();
            end
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] c, input logic [7:0] tx, input logic [7:0] px);
        bus(1'b1, `SIO_CTL_ADDR, c);
        peer.load(px);
        bus(!c[2], `SIO_SHIFT_ADDR, tx);
        #1 chk("busy", 32'h1, {31'h0, busy});
        for (int i = 0; i < 16 && c[1:0] == 2'b00; i++)
        begin
            repeat (20) @(posedge clk);
            ext_sck <= i[0];
        end
        for (int n = 0; transfer_done_flag !== 1'b1 && n < 5000; n++)
            @(posedge clk);
        chk("done", 32'h1, {31'h0, transfer_done_flag});
        bus(1'b1, `SIO_CTL_ADDR, c & 8'hFB);
        bus(1'b0, `SIO_SHIFT_ADDR, 8'h00);
        chk("shift", {24'h0, px}, rd);
        if (!c[2])
            chk("peer", {24'h0, tx}, {24'h0, peer_rx});
        bus(1'b0, `SIO_STAT_ADDR, 8'h00);
        chk("status", 32'h1, rd);
        bus(1'b1, `SIO_STAT_ADDR, 8'h01);
        bus(1'b0, `SIO_STAT_ADDR, 8'h00);
        chk("cleared", 32'h0, rd);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (30000) @(posedge clk);
        failures++;
        summarize();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, `SIO_CTL_ADDR, 8'h00);
        chk("ctl", {24'h0, `SIO_CTL_RESET}, rd);
        bus(1'b0, 16'h0000, 8'h00);
        chk("unmapped", 32'h1, {31'h0, err});
        for (int s = 1; s < 4; s++)
            xfer(8'h80 | s[7:0], 8'h3C ^ s[7:0], 8'hA5 + s[7:0]);
        xfer(8'h85, 8'h00, 8'h5A);
        xfer(8'h80, 8'hC3, 8'h96);
        bus(1'b1, `SIO_CTL_ADDR, 8'h00);
        bus(1'b1, `SIO_SHIFT_ADDR, 8'h11);
        bus(1'b1, `SIO_CTL_ADDR, 8'h81);
        repeat (100) @(posedge clk);
        #1 chk("idle", 32'h0, {31'h0, busy});
        peer.load(8'hFF);
        bus(1'b1, `SIO_SHIFT_ADDR, 8'hF0);
        repeat (72) @(posedge clk);
        bus(1'b1, `SIO_CTL_ADDR, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk("abort", 32'h0, {31'h0, busy});
        xfer(8'h81, 8'h0F, 8'h69);
        summarize();
    end
endmodule
`default_nettype wire
